// >>> mac_model.sv
// mac side: strap resistors on released pins, receive samplers
`timescale 1ns/100ps
module mac_model (
  input wire logic ref_clk_in,
  input wire logic rmii_mode,
  input wire logic [3:0] st_rxd,
  input wire logic st_er,
  input wire logic st_clk,
  input wire logic st_crs,
  input wire logic [3:0] rxd_out,
  input wire logic [3:0] rxd_oe_n,
  input wire logic rx_er_out,
  input wire logic rx_er_oe_n,
  input wire logic rx_clk_out,
  input wire logic rx_clk_oe_n,
  input wire logic col_crs_dv_out,
  input wire logic col_crs_dv_oe_n,
  input wire logic rx_dv,
  output logic [3:0] rxd_in,
  output logic rx_er_in,
  output logic rx_clk_in,
  output logic col_crs_dv_in,
  output logic [3:0] last_nib,
  output int nib_cnt,
  output logic [1:0] dibit_or
);
  // released pin shows its resistor level, never a stale value
  for (genvar i = 0; i < 4; i++) begin : g_pin
    assign rxd_in[i] = rxd_oe_n[i] ? st_rxd[i] : rxd_out[i];
  end
  assign rx_er_in = rx_er_oe_n ? st_er : rx_er_out;
  assign rx_clk_in = rx_clk_oe_n ? st_clk : rx_clk_out;
  assign col_crs_dv_in = col_crs_dv_oe_n ? st_crs : col_crs_dv_out;
  initial begin
    nib_cnt = 0;
    last_nib = 4'h0;
    dibit_or = 2'h0;
  end
  // error line never read in rmii, so the mac works without it
  always @(posedge rx_clk_out) begin
    if (!rmii_mode && rx_dv === 1'b1) begin
      last_nib <= rxd_out;
      nib_cnt <= nib_cnt + 1;
    end
  end
  always @(posedge ref_clk_in) begin
    if (rmii_mode) dibit_or <= dibit_or | rxd_out[1:0];
  end
endmodule // mac_model

// >>> mii_rmii_rx.sv
// mii/rmii receive pin logic with strap capture and axi4-lite registers
`timescale 1ns/100ps
// Functional notes
// - mii drives rxd bit three; rmii leaves that line without data.
// - four bits per receive clock in mii, two lowest bits in rmii.
// - interface strap low selects mii, high selects rmii.
// - management address from three pulled-down strap pins.
// - default operating mode from three pulled-up straps, one on crs_dv.
// - straps captured at power-on and system reset, held until next.
// - receive error asserted for an error within the current frame.
// - eee: error line means frame error with valid, low-power idle without.
// - symbol mode puts the fifth code-group bit on the error pin.
// - outside symbol mode the shared pin is receive error, or low-power idle with eee.
// - mii receive clock is 25 mhz at 100 mb/s, 2.5 mhz at 10; the 100 ns aclk gives 5 mhz at 100.
// - data valid only while decoded data sits on the data lines.
// - mii collision output follows a collision on the medium.
// - mii carrier sense follows carrier; defaults low.
// - rmii carrier/valid asserted while the medium is not idle.
// - rmii 10 mb/s keeps data low until the sfd byte arrives.
// - rmii 10 mb/s half duplex never echoes own transmit data.
module mii_rmii_rx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] line_data,
  input wire logic line_valid,
  input wire logic line_err,
  input wire logic line_carrier,
  input wire logic line_col,
  input wire logic line_lpi,
  input wire logic line_echo,
  output logic line_ready,
  input wire logic ref_clk_in,
  input wire logic [3:0] rxd_in,
  output logic [3:0] rxd_out,
  output logic [3:0] rxd_oe_n,
  input wire logic rx_er_in,
  output logic rx_er_out,
  output logic rx_er_oe_n,
  input wire logic rx_clk_in,
  output logic rx_clk_out,
  output logic rx_clk_oe_n,
  input wire logic col_crs_dv_in,
  output logic col_crs_dv_out,
  output logic col_crs_dv_oe_n,
  output logic rx_dv,
  output logic crs,
  output logic [2:0] mgmt_addr,
  output logic [2:0] op_mode,
  output logic rmii_mode,
  output logic straps_valid
);
  typedef struct packed {
    rx_cfg_pkg::strap_phase_e phase;
    logic [1:0] hold_cnt;
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    logic [2:0] mgmt_addr;
    logic [2:0] op_mode;
    logic rmii;
    logic speed_100;
    logic full_dup;
    logic symbol_mode;
    logic eee_en;
    logic [3:0] rxd;
    logic dv;
    logic er;
    logic cc;
    logic crs;
    logic dib_hi;
    logic [3:0] rep_cnt;
    logic [3:0] cur;
    logic [3:0] sfd_prev;
    logic sfd_seen;
    logic in_frame;
    logic frame_err;
    logic [15:0] frames;
    logic [15:0] errors;
    logic aw_held;
    logic [11:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s r;
  state_s n;
  logic run;
  logic take;
  logic data_ok;
  logic sfd_hit;
  logic sfd_gate;
  logic [3:0] nib;
  logic er_val;
  logic [3:0] reps_m1;
  logic [6:0] pins;

  rx_timing_if tim ();

  rx_step_gen u_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_clk_in(ref_clk_in),
    .tim(tim)
  );

  function automatic logic is_mapped(input logic [11:0] a);
    return (a == rx_cfg_pkg::REG_CTRL) || (a == rx_cfg_pkg::REG_STATUS) ||
      (a == rx_cfg_pkg::REG_FRAMES) || (a == rx_cfg_pkg::REG_ERRORS);
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input state_s s);
    logic [31:0] w;
    w = '0;
    if (a == rx_cfg_pkg::REG_CTRL) begin
      w[rx_cfg_pkg::CTRL_SPEED100] = s.speed_100;
      w[rx_cfg_pkg::CTRL_FULLDUP] = s.full_dup;
      w[rx_cfg_pkg::CTRL_SYMBOL] = s.symbol_mode;
      w[rx_cfg_pkg::CTRL_EEE] = s.eee_en;
    end else if (a == rx_cfg_pkg::REG_STATUS) begin
      w[rx_cfg_pkg::STAT_ADDR_LSB +: 3] = s.mgmt_addr;
      w[rx_cfg_pkg::STAT_OP_LSB +: 3] = s.op_mode;
      w[rx_cfg_pkg::STAT_RMII] = s.rmii;
      w[rx_cfg_pkg::STAT_FRAME] = s.in_frame;
      w[rx_cfg_pkg::STAT_RUN] = (s.phase == rx_cfg_pkg::PH_RUN);
    end else if (a == rx_cfg_pkg::REG_FRAMES) begin
      w[15:0] = s.frames;
    end else if (a == rx_cfg_pkg::REG_ERRORS) begin
      w[15:0] = s.errors;
    end
    return w;
  endfunction

  assign tim.rmii = r.rmii;
  assign tim.speed_100 = r.speed_100;
  assign run = (r.phase == rx_cfg_pkg::PH_RUN);
  // rmii takes a fresh nibble only once both dibits are out
  assign line_ready = run & tim.step &
    (~r.rmii | ((r.rep_cnt == '0) & ~r.dib_hi));
  assign take = line_ready;

  // strap pins, in the order of the sample vector
  assign pins = {rx_clk_in, rx_er_in, rxd_in[3], rxd_in[2],
                 col_crs_dv_in, rxd_in[1], rxd_in[0]};

  always_comb begin
    n = r;
    n.pin_s1 = pins;
    n.pin_s2 = r.pin_s1;
    // own transmit echo is dropped in rmii 10 mb/s half duplex, never shown as received data
    data_ok = line_valid & ~(r.rmii & ~r.speed_100 & ~r.full_dup &
      line_echo);
    sfd_hit = data_ok & ({line_data[3:0], r.sfd_prev} ==
      rx_cfg_pkg::SFD_BYTE);
    sfd_gate = ~r.rmii | r.speed_100 | r.sfd_seen | sfd_hit;
    nib = (data_ok & sfd_gate) ? line_data[3:0] : 4'h0;
    if (r.symbol_mode) begin
      er_val = line_valid & line_data[4];
    end else if (data_ok) begin
      er_val = line_err;
    end else begin
      er_val = r.eee_en & line_lpi;
    end
    reps_m1 = r.speed_100 ? rx_cfg_pkg::RMII_REP_100_M1
                          : rx_cfg_pkg::RMII_REP_10_M1;

    if (r.phase == rx_cfg_pkg::PH_HOLD) begin
      // pins released while the straps settle through the synchroniser
      n.rxd = '0;
      n.dv = 1'b0;
      n.er = 1'b0;
      n.cc = 1'b0;
      n.crs = 1'b0;
      n.dib_hi = 1'b0;
      n.rep_cnt = '0;
      n.in_frame = 1'b0;
      n.frame_err = 1'b0;
      n.sfd_seen = 1'b0;
      n.hold_cnt = r.hold_cnt + 2'h1;
      if (r.hold_cnt == rx_cfg_pkg::STRAP_HOLD_M1) begin
        n.phase = rx_cfg_pkg::PH_RUN;
        n.rmii = r.pin_s2[rx_cfg_pkg::STRAP_RMII];
        n.mgmt_addr = {r.pin_s2[rx_cfg_pkg::STRAP_ADDR2],
                       r.pin_s2[rx_cfg_pkg::STRAP_ADDR1],
                       r.pin_s2[rx_cfg_pkg::STRAP_ADDR0]};
        n.op_mode = {r.pin_s2[rx_cfg_pkg::STRAP_OP2],
                     r.pin_s2[rx_cfg_pkg::STRAP_OP1],
                     r.pin_s2[rx_cfg_pkg::STRAP_OP0]};
        n.speed_100 = r.pin_s2[rx_cfg_pkg::STRAP_OP0];
        n.full_dup = r.pin_s2[rx_cfg_pkg::STRAP_OP1];
        n.eee_en = r.pin_s2[rx_cfg_pkg::STRAP_OP2];
      end
    end else if (tim.step) begin
      n.crs = r.rmii ? 1'b0 : line_carrier;
      n.cc = r.rmii ? line_carrier : line_col;
      if (take) begin
        n.er = er_val;
        n.sfd_prev = data_ok ? line_data[3:0] : 4'h0;
        n.sfd_seen = line_valid & (r.sfd_seen | sfd_hit);
        if (!line_valid) begin
          n.in_frame = 1'b0;
          n.frame_err = 1'b0;
        end else if (data_ok && !r.in_frame) begin
          n.in_frame = 1'b1;
          n.frames = r.frames + 16'h0001;
        end
        if (data_ok && line_err && !r.frame_err) begin
          n.frame_err = 1'b1;
          n.errors = r.errors + 16'h0001;
        end
      end
      if (!r.rmii) begin
        n.rxd = nib;
        n.dv = data_ok;
      end else if (r.rep_cnt != '0) begin
        // 10 mb/s rmii repeats each dibit on ten reference edges
        n.rep_cnt = r.rep_cnt - 4'h1;
      end else if (!r.dib_hi) begin
        n.cur = nib;
        n.rxd = {2'h0, nib[1:0]};
        n.dv = data_ok;
        n.dib_hi = 1'b1;
        n.rep_cnt = reps_m1;
      end else begin
        n.rxd = {2'h0, r.cur[3:2]};
        n.dib_hi = 1'b0;
        n.rep_cnt = reps_m1;
      end
    end

    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_held = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = is_mapped(r.awaddr) ? rx_cfg_pkg::RESP_OKAY
                                    : rx_cfg_pkg::RESP_SLVERR;
      if (r.awaddr == rx_cfg_pkg::REG_CTRL && r.wstrb[0]) begin
        n.speed_100 = r.wdata[rx_cfg_pkg::CTRL_SPEED100];
        n.full_dup = r.wdata[rx_cfg_pkg::CTRL_FULLDUP];
        n.symbol_mode = r.wdata[rx_cfg_pkg::CTRL_SYMBOL];
        n.eee_en = r.wdata[rx_cfg_pkg::CTRL_EEE];
        if (r.wdata[rx_cfg_pkg::CTRL_SYSRST]) begin
          n.phase = rx_cfg_pkg::PH_HOLD;
          n.hold_cnt = '0;
        end
      end
    end
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end else if (s_axi_arvalid && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rdata = read_word(s_axi_araddr, r);
      n.rresp = is_mapped(s_axi_araddr) ? rx_cfg_pkg::RESP_OKAY
                                        : rx_cfg_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready = ~r.aw_held & ~r.bvalid;
  assign s_axi_wready = ~r.w_held & ~r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = ~r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  assign rxd_out = r.rxd;
  assign rxd_oe_n[1:0] = {2{~run}};
  // upper nibble lines idle in rmii
  assign rxd_oe_n[3:2] = {2{~(run & ~r.rmii)}};
  assign rx_er_out = r.er;
  assign rx_er_oe_n = ~run;
  assign rx_clk_out = tim.rx_clk_level;
  assign rx_clk_oe_n = ~(run & ~r.rmii);
  assign col_crs_dv_out = r.cc;
  assign col_crs_dv_oe_n = ~run;
  assign rx_dv = r.dv;
  assign crs = r.crs;
  assign mgmt_addr = r.mgmt_addr;
  assign op_mode = r.op_mode;
  assign rmii_mode = r.rmii;
  assign straps_valid = run;
endmodule // mii_rmii_rx

// >>> mii_rmii_rx_assertions.sv
// assertion checker for the mii/rmii receive block
`timescale 1ns/100ps
module rx_pin_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic line_ready,
  input wire logic line_valid,
  input wire logic line_carrier,
  input wire logic line_col,
  input wire logic [3:0] rxd_out,
  input wire logic [3:0] rxd_oe_n,
  input wire logic rx_clk_out,
  input wire logic rx_clk_oe_n,
  input wire logic col_crs_dv_out,
  input wire logic rx_dv,
  input wire logic crs,
  input wire logic [2:0] mgmt_addr,
  input wire logic rmii_mode,
  input wire logic straps_valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire mii = straps_valid & ~rmii_mode;
  wire rmii = straps_valid & rmii_mode;
  sequence take_mii_s;
    line_ready && mii;
  endsequence
  a_rmii_upper_off: assert property (
    rmii |-> rxd_oe_n[3:2] == 2'b11 && rx_clk_oe_n && !crs)
    else $error("rmii upper pins driven");
  a_mii_all_driven: assert property (
    mii |-> rxd_oe_n == 4'h0) else $error("mii data pins released");
  a_valid_from_take: assert property (
    $rose(rx_dv) && mii |-> $past(line_ready && line_valid))
    else $error("data valid without framed nibble");
  a_strap_held: assert property (
    straps_valid && $past(straps_valid) |->
    $stable(mgmt_addr) && $stable(rmii_mode))
    else $error("captured straps moved");
  a_crs_dv_follows: assert property (
    line_ready && rmii |=> col_crs_dv_out == $past(line_carrier))
    else $error("carrier/valid wrong");
  a_mii_col_crs: assert property (
    take_mii_s |=> col_crs_dv_out == $past(line_col) &&
    crs == $past(line_carrier)) else $error("collision or carrier wrong");
  a_data_on_fall: assert property (
    mii && $changed({rxd_out, rx_dv}) |-> $fell(rx_clk_out))
    else $error("data moved off the receive clock fall");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
endmodule // rx_pin_checker
bind mii_rmii_rx rx_pin_checker u_chk (.*);

// >>> rx_cfg_pkg.sv
// constants, register map and state types for the mii/rmii receive block
package rx_cfg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RXCLK_100_PERIOD_NS = 40;
  localparam int unsigned RXCLK_10_PERIOD_NS = 400;

  // longest half period, rounded down, never below one cycle
  function automatic int unsigned floor_cycles(input int unsigned ns);
    int unsigned c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0] HALF_100_M1 =
    4'(floor_cycles(RXCLK_100_PERIOD_NS / 2) - 1);
  localparam logic [3:0] HALF_10_M1 =
    4'(floor_cycles(RXCLK_10_PERIOD_NS / 2) - 1);

  localparam logic [1:0] STRAP_HOLD_M1 = 2'h2;
  localparam logic [3:0] RMII_REP_100_M1 = 4'h0;
  localparam logic [3:0] RMII_REP_10_M1 = 4'h9;
  localparam logic [7:0] SFD_BYTE = 8'hab;

  // strap pin sample vector layout
  localparam int STRAP_OP0 = 0;
  localparam int STRAP_OP1 = 1;
  localparam int STRAP_OP2 = 2;
  localparam int STRAP_RMII = 3;
  localparam int STRAP_ADDR2 = 4;
  localparam int STRAP_ADDR0 = 5;
  localparam int STRAP_ADDR1 = 6;
  localparam int STRAP_W = 7;

  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_FRAMES = 12'h008;
  localparam logic [11:0] REG_ERRORS = 12'h00c;

  localparam int CTRL_SPEED100 = 0;
  localparam int CTRL_FULLDUP = 1;
  localparam int CTRL_SYMBOL = 2;
  localparam int CTRL_EEE = 3;
  localparam int CTRL_SYSRST = 4;

  localparam int STAT_ADDR_LSB = 0;
  localparam int STAT_OP_LSB = 3;
  localparam int STAT_RMII = 6;
  localparam int STAT_FRAME = 7;
  localparam int STAT_RUN = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {PH_HOLD, PH_RUN} strap_phase_e;
endpackage

// >>> rx_step_gen.sv
// receive clock divider and rmii reference clock edge finder
`timescale 1ns/100ps
module rx_step_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ref_clk_in,
  rx_timing_if.gen tim
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [3:0] div_cnt;
    logic lvl;
  } gen_s;

  gen_s r;
  gen_s n;
  logic [3:0] half_m1;
  logic at_end;

  assign half_m1 = tim.speed_100 ? rx_cfg_pkg::HALF_100_M1
                                 : rx_cfg_pkg::HALF_10_M1;
  assign at_end = (r.div_cnt >= half_m1);
  // mii: step on the edge where the clock falls, data settles for rise
  assign tim.step = tim.rmii ? (r.s2 & ~r.s3) : (r.lvl & at_end);
  assign tim.rx_clk_level = r.lvl;

  always_comb begin
    n = r;
    n.s1 = ref_clk_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (tim.rmii) begin
      n.div_cnt = '0;
      n.lvl = 1'b0;
    end else if (at_end) begin
      n.div_cnt = '0;
      n.lvl = ~r.lvl;
    end else begin
      n.div_cnt = r.div_cnt + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // rx_step_gen

// >>> rx_timing_if.sv
// receive step timing between the main block and its step generator
`timescale 1ns/100ps
interface rx_timing_if;
  logic rmii;
  logic speed_100;
  logic step;
  logic rx_clk_level;
  modport ctrl (output rmii, output speed_100, input step,
    input rx_clk_level);
  modport gen (input rmii, input speed_100, output step,
    output rx_clk_level);
endinterface

// >>> tb_mii_rmii_rx.sv
// self-checking bench for the mii/rmii receive block
`timescale 1ns/100ps
module tb_mii_rmii_rx;
  logic aclk, aresetn, ref_clk_in;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, dibit_or;
  logic [4:0] line_data;
  logic line_valid, line_err, line_carrier, line_col, line_lpi, line_echo;
  logic line_ready, rx_er_in, rx_er_out, rx_er_oe_n, rx_clk_in, rx_clk_out;
  logic [3:0] rxd_in, rxd_out, rxd_oe_n, st_rxd, last_nib;
  logic rx_clk_oe_n, col_crs_dv_in, col_crs_dv_out, col_crs_dv_oe_n;
  logic rx_dv, crs, rmii_mode, straps_valid, st_er, st_clk, st_crs;
  logic [2:0] mgmt_addr, op_mode;
  int nib_cnt, fails, compares;
  mii_rmii_rx u_dut (.*);
  mac_model u_mac (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    bit aw_done, w_done;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && !aw_done) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && !w_done) s_axi_wvalid <= 1'b0;
      aw_done |= s_axi_awready;
      w_done |= s_axi_wready;
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    // rready stays up between reads: a back-to-back read never lowers
    // and raises it in one time step
  endtask
  // returns at the take edge; outputs then still show the previous take
  task automatic send(input logic [4:0] d, input logic v, e, lpi, echo);
    line_data <= d;
    line_valid <= v;
    line_err <= e;
    line_lpi <= lpi;
    line_echo <= echo;
    do @(posedge aclk); while (!line_ready);
  endtask
  task automatic clk_period(input logic [31:0] exp);
    realtime t;
    @(posedge rx_clk_out);
    t = $realtime;
    @(posedge rx_clk_out);
    chk($rtoi($realtime - t), exp);
  endtask
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    ref_clk_in = 1'b0;
    forever #400 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #2_000_000;
    fails++;
    print_verdict();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, line_data, line_valid, line_err} = '0;
    {line_carrier, line_col, line_lpi, line_echo} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    // addr 5, mii, all op straps high
    st_rxd = 4'hb;
    st_er = 1'b1;
    st_clk = 1'b0;
    st_crs = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    do @(posedge aclk); while (!straps_valid);
    chk(mgmt_addr, 3'h5);
    chk(op_mode, 3'h7);
    chk(rmii_mode, 1'b0);
    axi_rd(12'h004, d, r);
    chk(d[8:0], 9'h13d);
    axi_rd(12'h010, d, r);
    chk(r, 2'h2);
    chk(d, 32'h0);
    line_carrier <= 1'b1;
    for (int i = 0; i < 4; i++) send(5'(9 + 5 * i), 1, 0, 0, 0);
    send(5'h0, 0, 0, 0, 0);
    chk(nib_cnt, 4);
    chk(last_nib, 4'h8);
    chk(crs, 1'b1);
    send(5'h2, 1, 1, 0, 0);
    line_col <= 1'b1;
    send(5'h2, 1, 0, 1, 0);
    chk(rx_er_out, 1'b1);
    send(5'h0, 0, 0, 1, 0);
    chk(rx_er_out, 1'b0);
    chk(col_crs_dv_out, 1'b1);
    line_col <= 1'b0;
    line_carrier <= 1'b0;
    send(5'h0, 0, 0, 0, 0);
    chk(rx_er_out, 1'b1);
    send(5'h0, 0, 0, 0, 0);
    chk(crs, 1'b0);
    clk_period(200);
    axi_wr(12'h000, 32'h5);
    send(5'h10, 1, 0, 0, 0);
    send(5'h00, 1, 1, 0, 0);
    chk(rx_er_out, 1'b1);
    send(5'h00, 0, 0, 0, 0);
    chk(rx_er_out, 1'b0);
    axi_wr(12'h000, 32'h1);
    send(5'h10, 1, 0, 0, 0);
    send(5'h00, 0, 0, 0, 0);
    chk(rx_er_out, 1'b0);
    axi_wr(12'h000, 32'h0);
    clk_period(400);
    // recapture: rmii, addr 2, 10 mb/s half duplex, eee on
    st_rxd <= 4'h4;
    st_er <= 1'b0;
    st_clk <= 1'b1;
    axi_wr(12'h000, 32'h10);
    repeat (8) @(posedge aclk);
    do @(posedge aclk); while (!straps_valid);
    chk(mgmt_addr, 3'h2);
    chk(op_mode, 3'h4);
    chk(rmii_mode, 1'b1);
    chk({rxd_oe_n[3:2], rx_clk_oe_n}, 3'h7);
    chk({rxd_oe_n[1:0], rx_er_oe_n, col_crs_dv_oe_n}, 4'h0);
    line_carrier <= 1'b1;
    repeat (2) send(5'h5, 1, 0, 0, 1);
    repeat (2) send(5'h5, 1, 0, 0, 0);
    send(5'hb, 1, 0, 0, 0);
    send(5'ha, 1, 0, 0, 0);
    chk(dibit_or, 2'h0);
    chk(col_crs_dv_out, 1'b1);
    // own echo after the sfd would set bit 0 if it leaked through
    send(5'h1, 1, 0, 0, 1);
    send(5'h3, 1, 0, 0, 0);
    chk(dibit_or, 2'h2);
    send(5'h0, 0, 0, 0, 0);
    chk(dibit_or, 2'h3);
    print_verdict();
  end
endmodule // tb_mii_rmii_rx
